/* File: hdl/spic_map.svh */
`ifndef SPIC_MAP_SVH
`define SPIC_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SPIC_ADDR_W 4
`define SPIC_ADDR_CTRL 4'h0
`define SPIC_ADDR_UNLOCK 4'h4
`define SPIC_ADDR_STATUS 4'h8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SPIC_DIV_HI 10
`define SPIC_DIV_LO 8
`define SPIC_SRC_BIT 7
`define SPIC_RNG_HI 2
`define SPIC_RNG_LO 0
`define SPIC_DIV_LANE 1
`define SPIC_LOW_LANE 0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define SPIC_ST_UNLOCKED 0
`define SPIC_ST_REF_LOCKED 1
`define SPIC_ST_REF_ACTIVE 2
`define SPIC_ST_RNG_RSVD 3
`define SPIC_ST_COSC_HI 6
`define SPIC_ST_COSC_LO 4

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define SPIC_COSC_PLL 3'h1
`define SPIC_RNG_BYPASS 3'h0
`define SPIC_RNG_5_10 3'h1
`define SPIC_RNG_8_16 3'h2
`define SPIC_RNG_13_26 3'h3
`define SPIC_RNG_21_42 3'h4
`define SPIC_RNG_34_64 3'h5
`define SPIC_DIV_BY_ONE 3'h0
`define SPIC_RESP_OKAY 2'h0
`define SPIC_RESP_SLVERR 2'h2
`define SPIC_WORD_ZERO 32'h00000000
`define SPIC_FLAG_ZERO 2'h0

`endif

/* File: hdl/spic_pkg.sv */
`include "spic_map.svh"

package spic_pkg;

	typedef enum logic [2:0] {
		SPIC_BYPASS = `SPIC_RNG_BYPASS,
		SPIC_R5_10 = `SPIC_RNG_5_10,
		SPIC_R8_16 = `SPIC_RNG_8_16,
		SPIC_R13_26 = `SPIC_RNG_13_26,
		SPIC_R21_42 = `SPIC_RNG_21_42,
		SPIC_R34_64 = `SPIC_RNG_34_64
	} spic_range_type;

	typedef enum logic [1:0] {
		SPIC_UNL_IDLE,
		SPIC_UNL_KEY1,
		SPIC_UNL_OPEN
	} spic_unlock_state_type;

endpackage

/* File: hdl/spic_sync.sv */
`timescale 1ns/1ps

module spic_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* File: hdl/spic_ref_div.sv */
`timescale 1ns/1ps
`include "spic_map.svh"

module spic_ref_div #(
	parameter int DIV_W = 3
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic frc_edge_in,
	input wire logic primary_oscillator_edge_in,
	input wire logic sel_frc_in,
	input wire logic [DIV_W-1:0] div_code_in,
	output logic [DIV_W-1:0] eff_code_out,
	output logic tick_out
);

	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	logic tick_nxt;
	logic [DIV_W-1:0] eff_code;
	logic src_edge;

	assign eff_code = sel_frc_in ? DIV_W'(`SPIC_DIV_BY_ONE) : div_code_in;
	assign src_edge = sel_frc_in ? frc_edge_in : primary_oscillator_edge_in;

	// A shrinking ratio must not strand the count above the new terminal value.
	assign tick_nxt = src_edge && (cnt_r >= eff_code);
	assign cnt_nxt = !src_edge ? cnt_r : (tick_nxt ? '0 : cnt_r + 1'b1);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_r <= '0;
			tick_out <= 1'b0;
			eff_code_out <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_out <= tick_nxt;
			eff_code_out <= eff_code;
		end
	end

endmodule

/* File: hdl/spic_top.sv */
`timescale 1ns/1ps
`include "spic_map.svh"


module spic_top #(
	parameter logic [31:0] UNLOCK_KEY_A = 32'h5a5a0f0f,
	parameter logic [31:0] UNLOCK_KEY_B = 32'ha5a5f0f0,
	parameter int DIV_W = 3,
	parameter int RNG_W = 3
) (
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic [`SPIC_ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	output logic [1:0] AVS_RESPONSE_OUT,
	input wire logic [DIV_W-1:0] CFG_INPUT_DIVIDER_DEFAULT_IN,
	input wire logic CFG_REF_SOURCE_DEFAULT_IN,
	input wire logic [RNG_W-1:0] CFG_RANGE_DEFAULT_IN,
	input wire logic [2:0] CURRENT_SYSCLK_SOURCE_IN,
	input wire logic INTERNAL_FAST_RC_OSC_IN,
	input wire logic PRIMARY_OSCILLATOR_IN,
	output logic REF_SOURCE_SELECT_OUT,
	output logic [DIV_W-1:0] REF_INPUT_DIVIDER_OUT,
	output logic [RNG_W-1:0] PLL_RANGE_OUT,
	output logic PLL_BYPASS_OUT,
	output logic PLL_RANGE_RESERVED_OUT,
	output logic PLL_REF_TICK_OUT
);

	// ------------------------------------------------------------------------
	// Control register state
	// ------------------------------------------------------------------------
	logic [DIV_W-1:0] ref_input_divider_r;
	logic [DIV_W-1:0] ref_input_divider_nxt;
	logic ref_source_select_r;
	logic ref_source_select_nxt;
	logic [RNG_W-1:0] range_r;
	logic [RNG_W-1:0] range_nxt;

	// ------------------------------------------------------------------------
	// Bus, unlock and status state
	// ------------------------------------------------------------------------
	logic ack_r;
	logic [31:0] readdata_r;
	logic [1:0] response_r;
	spic_pkg::spic_unlock_state_type unlock_r;
	spic_pkg::spic_unlock_state_type unlock_nxt;
	logic ref_locked_r;
	logic ref_locked_nxt;
	logic ref_active_r;
	logic ref_active_nxt;
	logic bypass_r;
	logic rsvd_r;

	// ------------------------------------------------------------------------
	// Oscillator sampling
	// ------------------------------------------------------------------------
	logic [1:0] osc_sync;
	logic [1:0] osc_prev_r;
	logic [1:0] osc_rise;
	logic [DIV_W-1:0] eff_code;
	logic ref_tick;

	// ------------------------------------------------------------------------
	// Address decode and bus handshake
	// ------------------------------------------------------------------------
	wire bus_req = AVS_READ_IN | AVS_WRITE_IN;
	wire sel_ctrl = (AVS_ADDRESS_IN == `SPIC_ADDR_CTRL);
	wire sel_unlock = (AVS_ADDRESS_IN == `SPIC_ADDR_UNLOCK);
	wire sel_status = (AVS_ADDRESS_IN == `SPIC_ADDR_STATUS);
	wire sel_hit = sel_ctrl | sel_unlock | sel_status;
	wire wr_done = AVS_WRITE_IN & ack_r;
	wire rd_first = AVS_READ_IN & ~ack_r;
	wire first_cycle = bus_req & ~ack_r;
	wire wr_ctrl = wr_done & sel_ctrl;
	wire wr_unlock = wr_done & sel_unlock;
	wire wr_status = wr_done & sel_status;

	// Every access stalls exactly one cycle so read data can come from a flop.
	assign AVS_WAITREQUEST_OUT = bus_req & ~ack_r;
	assign AVS_READDATA_OUT = readdata_r;
	assign AVS_RESPONSE_OUT = response_r;

	// ------------------------------------------------------------------------
	// Write qualification
	// ------------------------------------------------------------------------
	wire pll_active = (CURRENT_SYSCLK_SOURCE_IN == `SPIC_COSC_PLL);
	wire unlocked = (unlock_r == spic_pkg::SPIC_UNL_OPEN);
	wire refuse_locked = wr_ctrl & ~unlocked;
	wire refuse_active = wr_ctrl & pll_active;
	wire wr_accept = wr_ctrl & ~refuse_locked & ~refuse_active;
	wire lane_div = AVS_BYTEENABLE_IN[`SPIC_DIV_LANE];
	wire lane_low = AVS_BYTEENABLE_IN[`SPIC_LOW_LANE];
	wire key_a = (AVS_WRITEDATA_IN == UNLOCK_KEY_A);
	wire key_b = (AVS_WRITEDATA_IN == UNLOCK_KEY_B);

	// Only an accepted write reaches the fields; byte lanes gate each field.
	assign ref_input_divider_nxt = (wr_accept & lane_div) ?
		AVS_WRITEDATA_IN[`SPIC_DIV_HI:`SPIC_DIV_LO] : ref_input_divider_r;
	assign ref_source_select_nxt = (wr_accept & lane_low) ?
		AVS_WRITEDATA_IN[`SPIC_SRC_BIT] : ref_source_select_r;
	assign range_nxt = (wr_accept & lane_low) ?
		AVS_WRITEDATA_IN[`SPIC_RNG_HI:`SPIC_RNG_LO] : range_r;

	// ------------------------------------------------------------------------
	// Unlock sequence
	// ------------------------------------------------------------------------
	// Key A then key B, as two consecutive writes, opens one control write.
	// Any write elsewhere between the keys, or any control write, closes it.
	always_comb begin
		unlock_nxt = unlock_r;
		case (unlock_r)
			spic_pkg::SPIC_UNL_IDLE: begin
				if (wr_unlock && key_a) begin
					unlock_nxt = spic_pkg::SPIC_UNL_KEY1;
				end
			end
			spic_pkg::SPIC_UNL_KEY1: begin
				if (wr_unlock && key_b) begin
					unlock_nxt = spic_pkg::SPIC_UNL_OPEN;
				end else if (wr_unlock && key_a) begin
					unlock_nxt = spic_pkg::SPIC_UNL_KEY1;
				end else if (wr_done) begin
					unlock_nxt = spic_pkg::SPIC_UNL_IDLE;
				end
			end
			spic_pkg::SPIC_UNL_OPEN: begin
				if (wr_unlock && key_a) begin
					unlock_nxt = spic_pkg::SPIC_UNL_KEY1;
				end else if (wr_unlock || wr_ctrl) begin
					unlock_nxt = spic_pkg::SPIC_UNL_IDLE;
				end
			end
			default: begin
				unlock_nxt = spic_pkg::SPIC_UNL_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Sticky refusal flags
	// ------------------------------------------------------------------------
	// A refusal in the same cycle as its clear still leaves the flag set.
	wire clr_locked = wr_status & lane_low & AVS_WRITEDATA_IN[`SPIC_ST_REF_LOCKED];
	wire clr_active = wr_status & lane_low & AVS_WRITEDATA_IN[`SPIC_ST_REF_ACTIVE];
	assign ref_locked_nxt = (ref_locked_r & ~clr_locked) | refuse_locked;
	assign ref_active_nxt = (ref_active_r & ~clr_active) | refuse_active;

	// ------------------------------------------------------------------------
	// Range decode
	// ------------------------------------------------------------------------
	wire rng_bypass = (range_r == spic_pkg::SPIC_BYPASS);
	wire rng_valid = (range_r == spic_pkg::SPIC_BYPASS) ||
		(range_r == spic_pkg::SPIC_R5_10) ||
		(range_r == spic_pkg::SPIC_R8_16) ||
		(range_r == spic_pkg::SPIC_R13_26) ||
		(range_r == spic_pkg::SPIC_R21_42) ||
		(range_r == spic_pkg::SPIC_R34_64);

	// ------------------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------------------
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] read_word;

	always_comb begin
		ctrl_word = `SPIC_WORD_ZERO;
		ctrl_word[`SPIC_DIV_HI:`SPIC_DIV_LO] = ref_input_divider_r;
		ctrl_word[`SPIC_SRC_BIT] = ref_source_select_r;
		ctrl_word[`SPIC_RNG_HI:`SPIC_RNG_LO] = range_r;
	end

	always_comb begin
		status_word = `SPIC_WORD_ZERO;
		status_word[`SPIC_ST_UNLOCKED] = unlocked;
		status_word[`SPIC_ST_REF_LOCKED] = ref_locked_r;
		status_word[`SPIC_ST_REF_ACTIVE] = ref_active_r;
		status_word[`SPIC_ST_RNG_RSVD] = rsvd_r;
		status_word[`SPIC_ST_COSC_HI:`SPIC_ST_COSC_LO] = CURRENT_SYSCLK_SOURCE_IN;
	end

	// The key register is write-only so the keys cannot be read back.
	assign read_word = sel_ctrl ? ctrl_word :
		(sel_status ? status_word : `SPIC_WORD_ZERO);

	wire [1:0] resp_word = sel_hit ? `SPIC_RESP_OKAY : `SPIC_RESP_SLVERR;

	// ------------------------------------------------------------------------
	// Bus registers
	// ------------------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			ack_r <= 1'b0;
			readdata_r <= `SPIC_WORD_ZERO;
			response_r <= `SPIC_RESP_OKAY;
		end else begin
			ack_r <= first_cycle;
			if (rd_first) begin
				readdata_r <= read_word;
			end
			if (first_cycle) begin
				response_r <= resp_word;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			unlock_r <= spic_pkg::SPIC_UNL_IDLE;
			ref_locked_r <= 1'b0;
			ref_active_r <= 1'b0;
		end else begin
			unlock_r <= unlock_nxt;
			ref_locked_r <= ref_locked_nxt;
			ref_active_r <= ref_active_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------------
	// The reset is synchronous, so the defaults are caught on every reset edge.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			ref_input_divider_r <= CFG_INPUT_DIVIDER_DEFAULT_IN;
			ref_source_select_r <= CFG_REF_SOURCE_DEFAULT_IN;
			range_r <= CFG_RANGE_DEFAULT_IN;
		end else begin
			ref_input_divider_r <= ref_input_divider_nxt;
			ref_source_select_r <= ref_source_select_nxt;
			range_r <= range_nxt;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			bypass_r <= 1'b0;
			rsvd_r <= 1'b0;
		end else begin
			bypass_r <= rng_bypass;
			rsvd_r <= ~rng_valid;
		end
	end

	assign REF_SOURCE_SELECT_OUT = ref_source_select_r;
	assign PLL_RANGE_OUT = range_r;
	assign PLL_BYPASS_OUT = bypass_r;
	assign PLL_RANGE_RESERVED_OUT = rsvd_r;

	// ------------------------------------------------------------------------
	// Oscillator inputs and reference divider
	// ------------------------------------------------------------------------
	// Edges are counted on the system clock, so each oscillator must run
	// below a quarter of it; faster sources need an analog divider ahead.
	spic_sync #(
		.WIDTH(2)
	) u_osc_sync (
		.clk_in(REF_CLK_IN),
		.rst_in(RST_IN),
		.async_in({PRIMARY_OSCILLATOR_IN, INTERNAL_FAST_RC_OSC_IN}),
		.sync_out(osc_sync)
	);

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			osc_prev_r <= 2'h0;
		end else begin
			osc_prev_r <= osc_sync;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_edge
			assign osc_rise[gi] = osc_sync[gi] & ~osc_prev_r[gi];
		end
	endgenerate

	spic_ref_div #(
		.DIV_W(DIV_W)
	) u_ref_div (
		.clk_in(REF_CLK_IN),
		.rst_in(RST_IN),
		.frc_edge_in(osc_rise[0]),
		.primary_oscillator_edge_in(osc_rise[1]),
		.sel_frc_in(ref_source_select_r),
		.div_code_in(ref_input_divider_r),
		.eff_code_out(eff_code),
		.tick_out(ref_tick)
	);

	assign REF_INPUT_DIVIDER_OUT = eff_code;
	assign PLL_REF_TICK_OUT = ref_tick;

endmodule

/* File: testbench/spic_props.sv */
`timescale 1ns/1ps
`include "spic_map.svh"

module spic_props #(
	parameter int DIV_W = 3,
	parameter int RNG_W = 3
) (
	input logic REF_CLK_IN,
	input logic RST_IN,
	input logic [`SPIC_ADDR_W-1:0] AVS_ADDRESS_IN,
	input logic AVS_READ_IN,
	input logic AVS_WRITE_IN,
	input logic [31:0] AVS_WRITEDATA_IN,
	input logic [3:0] AVS_BYTEENABLE_IN,
	input logic [31:0] AVS_READDATA_OUT,
	input logic AVS_WAITREQUEST_OUT,
	input logic [1:0] AVS_RESPONSE_OUT,
	input logic [DIV_W-1:0] CFG_INPUT_DIVIDER_DEFAULT_IN,
	input logic CFG_REF_SOURCE_DEFAULT_IN,
	input logic [RNG_W-1:0] CFG_RANGE_DEFAULT_IN,
	input logic [2:0] CURRENT_SYSCLK_SOURCE_IN,
	input logic INTERNAL_FAST_RC_OSC_IN,
	input logic PRIMARY_OSCILLATOR_IN,
	input logic REF_SOURCE_SELECT_OUT,
	input logic [DIV_W-1:0] REF_INPUT_DIVIDER_OUT,
	input logic [RNG_W-1:0] PLL_RANGE_OUT,
	input logic PLL_BYPASS_OUT,
	input logic PLL_RANGE_RESERVED_OUT,
	input logic PLL_REF_TICK_OUT
);
	// ------------------------------
	// Handshake and control fields
	// ------------------------------
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	wire req = AVS_READ_IN || AVS_WRITE_IN;
	wire ctl_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == `SPIC_ADDR_CTRL;
	wire pll_on = CURRENT_SYSCLK_SOURCE_IN == `SPIC_COSC_PLL;

	AST_WAIT_FIRST: assert property ($rose(req) |-> AVS_WAITREQUEST_OUT) else $error("no wait cycle");
	AST_WAIT_ONE: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT) else $error("long wait");
	AST_BYPASS: assert property (!$past(RST_IN) |-> PLL_BYPASS_OUT == ($past(PLL_RANGE_OUT) == 0))
		else $error("bypass flag wrong");
	AST_RSVD: assert property (!$past(RST_IN) |-> PLL_RANGE_RESERVED_OUT == ($past(PLL_RANGE_OUT) > 3'h5))
		else $error("reserved flag wrong");
	AST_DIV_FRC: assert property (!$past(RST_IN) && $past(REF_SOURCE_SELECT_OUT) |-> REF_INPUT_DIVIDER_OUT == 0)
		else $error("divider not one");
	AST_PLL_LOCK: assert property (ctl_wr && pll_on |=> $stable(PLL_RANGE_OUT) && $stable(REF_SOURCE_SELECT_OUT))
		else $error("write taken while pll active");
	AST_HOLD: assert property (!ctl_wr |=> $stable(PLL_RANGE_OUT) && $stable(REF_SOURCE_SELECT_OUT))
		else $error("field moved without write");
	AST_CFG_LOAD: assert property ($fell(RST_IN) |-> PLL_RANGE_OUT == $past(CFG_RANGE_DEFAULT_IN)
		&& REF_SOURCE_SELECT_OUT == $past(CFG_REF_SOURCE_DEFAULT_IN)) else $error("reset load wrong");
	AST_TICK: assert property (PLL_REF_TICK_OUT |=> !PLL_REF_TICK_OUT [*3]) else $error("tick too long");
	AST_CFG_DIV: assert property ($fell(RST_IN) |=> REF_INPUT_DIVIDER_OUT ==
		($past(REF_SOURCE_SELECT_OUT) ? 3'h0 : $past(CFG_INPUT_DIVIDER_DEFAULT_IN, 2))) else $error("divider reset load wrong");

	cover property (ctl_wr && pll_on);
	cover property (ctl_wr ##1 $changed(PLL_RANGE_OUT));
	cover property (PLL_REF_TICK_OUT && REF_INPUT_DIVIDER_OUT == 3'h7);
endmodule

bind spic_top spic_props #(.DIV_W(DIV_W), .RNG_W(RNG_W)) u_props (.*);

/* File: testbench/system_pll_input_config_test.sv */
`timescale 1ns/1ps
`include "spic_map.svh"

module system_pll_input_config_test;
	localparam logic [31:0] KEY_A = 32'h5a5a0f0f;
	localparam logic [31:0] KEY_B = 32'ha5a5f0f0;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, prim_osc = 1'b0, fast_osc = 1'b0, src_d = 1'b0;
	logic [3:0] adr = 4'h0, be = 4'hf;
	logic [31:0] wd = 32'h0, q;
	logic [2:0] div_d = 3'h0, rng_d = 3'h0, sys_src = 3'h0;
	logic [1:0] r;
	wire [31:0] rdat;
	wire [1:0] resp;
	wire [2:0] dout, rout;
	wire wreq, ssel, bypass, rsvd, tick;
	int error_cnt = 0, n_checks = 0, oc = 0, since = 0, gap = 0, nt = 0;

	spic_top #(.UNLOCK_KEY_A(KEY_A), .UNLOCK_KEY_B(KEY_B)) u_dut (
		.REF_CLK_IN(clk),
		.RST_IN(rst),
		.AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wd),
		.AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdat),
		.AVS_WAITREQUEST_OUT(wreq),
		.AVS_RESPONSE_OUT(resp),
		.CFG_INPUT_DIVIDER_DEFAULT_IN(div_d),
		.CFG_REF_SOURCE_DEFAULT_IN(src_d),
		.CFG_RANGE_DEFAULT_IN(rng_d),
		.CURRENT_SYSCLK_SOURCE_IN(sys_src),
		.INTERNAL_FAST_RC_OSC_IN(fast_osc),
		.PRIMARY_OSCILLATOR_IN(prim_osc),
		.REF_SOURCE_SELECT_OUT(ssel),
		.REF_INPUT_DIVIDER_OUT(dout),
		.PLL_RANGE_OUT(rout),
		.PLL_BYPASS_OUT(bypass),
		.PLL_RANGE_RESERVED_OUT(rsvd),
		.PLL_REF_TICK_OUT(tick)
	);

	initial forever #25 clk = ~clk;

	// ------------------------------
	// Oscillators and tick spacing
	// ------------------------------
	// Both oscillators stay well under a quarter of the bus clock, which the synchroniser needs.
	always @(posedge clk) begin
		oc <= oc + 1;
		if (oc % 5 == 4) prim_osc <= !prim_osc;
		if (oc % 7 == 6) fast_osc <= !fast_osc;
		since <= tick === 1'b1 ? 1 : since + 1;
		if (tick === 1'b1) gap <= since;
		nt <= nt + (tick === 1'b1);
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// The idle cycle at the end keeps a following request from driving the same signal twice at one edge.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdat;
		r = resp;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) begin
			chk(32'h0, 32'h1);
			close_out();
		end
		@(posedge clk);
	endtask

	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic unl();
		bus(1'b1, 4'h4, KEY_A);
		bus(1'b1, 4'h4, KEY_B);
	endtask

	function automatic logic [31:0] cv(input logic [2:0] d, input logic s, input logic [2:0] g);
		return {21'h0, d, s, 4'h0, g};
	endfunction

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset(input logic [2:0] d, input logic s, input logic [2:0] g);
		div_d <= d;
		src_d <= s;
		rng_d <= g;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(rout, g);
		chk(ssel, s);
		rchk(4'h0, cv(d, s, g));
		rchk(4'h8, {28'h0, g > 3'h5, 3'h0});
	endtask

	task automatic t_lock();
		bus(1'b1, 4'h0, cv(3'h6, 1'b1, 3'h4));
		bus(1'b1, 4'h4, KEY_B);
		bus(1'b1, 4'h0, cv(3'h6, 1'b1, 3'h4));
		rchk(4'h0, cv(3'h5, 1'b0, 3'h6));
		rchk(4'h8, 32'ha);
		bus(1'b1, 4'h8, 32'h2);
		rchk(4'h8, 32'h8);
	endtask

	task automatic t_unlock();
		unl();
		rchk(4'h8, 32'h9);
		chk(r, 2'h0);
		bus(1'b1, 4'h0, cv(3'h7, 1'b0, 3'h5));
		rchk(4'h0, cv(3'h7, 1'b0, 3'h5));
		bus(1'b1, 4'h0, cv(3'h0, 1'b1, 3'h2));
		chk(r, 2'h0);
		rchk(4'h0, cv(3'h7, 1'b0, 3'h5));
		rchk(4'h8, 32'h2);
		bus(1'b1, 4'hc, 32'hffffffff);
		chk(r, 2'h2);
		rchk(4'hc, 32'h0);
		chk(r, 2'h2);
	endtask

	task automatic t_pll();
		t_reset(3'h1, 1'b1, 3'h3);
		sys_src <= 3'h1;
		unl();
		bus(1'b1, 4'h0, cv(3'h4, 1'b0, 3'h1));
		rchk(4'h0, cv(3'h1, 1'b1, 3'h3));
		rchk(4'h8, 32'h14);
		sys_src <= 3'h0;
		unl();
		bus(1'b1, 4'h0, cv(3'h4, 1'b0, 3'h1));
		rchk(4'h0, cv(3'h4, 1'b0, 3'h1));
		// The refusal flag is sticky, so later status reads need it cleared here.
		bus(1'b1, 4'h8, 32'h4);
		rchk(4'h8, 32'h0);
	endtask

	task automatic t_range();
		for (int g = 0; g < 8; g++) begin
			unl();
			bus(1'b1, 4'h0, cv(3'h3, 1'b0, g[2:0]));
			chk(rout, g);
			// The range flags follow the field one cycle later.
			@(posedge clk);
			chk(bypass, g == 0);
			chk(rsvd, g > 5);
			rchk(4'h8, {28'h0, g > 5, 3'h0});
		end
	endtask

	// Pass nine selects the fast oscillator with a non-zero divider field, which must be ignored.
	task automatic t_div();
		int k;
		int n;
		for (int d = 0; d < 9; d++) begin
			unl();
			bus(1'b1, 4'h0, cv(d == 8 ? 3'h5 : d[2:0], d == 8, 3'h2));
			k = nt + 3;
			n = 0;
			while (nt < k && n < 400) begin
				@(posedge clk);
				n++;
			end
			if (n >= 400) begin
				chk(32'h0, 32'h1);
				close_out();
			end
			chk(ssel, d == 8);
			chk(dout, d == 8 ? 0 : d);
			chk(gap, d == 8 ? 14 : d * 10 + 10);
		end
	endtask

	initial begin
		t_reset(3'h5, 1'b0, 3'h6);
		t_lock();
		t_unlock();
		t_pll();
		t_range();
		t_div();
		close_out();
	end
endmodule
